// >>> design/gpx_defines.vh
// Purpose: Constants for the eight-pin port with external interrupt logic
// Assumes: APB slave, 32-bit data, byte addresses word aligned
// Notes:   Offsets are chosen locally; all values are `define macros
`ifndef GPX_DEFINES_VH
`define GPX_DEFINES_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define GPX_OFF_LATCH      12'h000
`define GPX_OFF_DIR        12'h004
`define GPX_OFF_OPTION     12'h008
`define GPX_OFF_SENSE      12'h00c
`define GPX_OFF_PENDING    12'h010
`define GPX_OFF_ALT_OUT_EN 12'h014
`define GPX_OFF_ALT_IN_EN  12'h018
`define GPX_OFF_PIN_LEVEL  12'h01c

// ****************************************************************
// Reset values
// ****************************************************************
`define GPX_RST_LATCH      8'h00
`define GPX_RST_DIR        8'h00
`define GPX_RST_OPTION     8'h00
`define GPX_RST_SENSE      8'h00
`define GPX_RST_ALT        8'h00

// ****************************************************************
// Sensitivity codes, two bits per vector
// ****************************************************************
`define GPX_SENSE_FALL_LOW 2'h0
`define GPX_SENSE_RISE     2'h1
`define GPX_SENSE_FALL     2'h2
`define GPX_SENSE_BOTH     2'h3

`endif

// >>> design/gpx_sync.v
// Purpose: Two-flop synchroniser for a vector of pin levels
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps

module gpx_sync #(
    parameter WIDTH = 8
) (
    // Clock and reset
    input  wire             clk,
    input  wire             rst_n,
    // Data
    input  wire [WIDTH-1:0] async_in,
    output reg  [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] stage1;

    // Two stages; reset high to match an idle pulled pin
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1   <= {WIDTH{1'b1}};
            sync_out <= {WIDTH{1'b1}};
        end else begin
            stage1   <= async_in;
            sync_out <= stage1;
        end
    end

endmodule

// >>> design/gpx_edge_det.v
// Purpose: Sensitivity-selectable edge/level detector for one vector
// Assumes: Input already synchronous to clk
// Notes:   Pulses one cycle on the selected edge; in level mode stays high while the level is low
`timescale 1ns/1ps
`include "gpx_defines.vh"

module gpx_edge_det (
    // Clock and reset
    input  wire       clk,
    input  wire       rst_n,
    // Source and control
    input  wire       level,
    input  wire [1:0] sense,
    output reg        event_hit
);

    reg prev;

    // Previous level; idle high so reset makes no edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev <= 1'b1;
        end else begin
            prev <= level;
        end
    end

    // Condition decode by sensitivity
    always @* begin
        case (sense)
            `GPX_SENSE_FALL_LOW: event_hit = ~level;
            `GPX_SENSE_RISE:     event_hit = level & ~prev;
            `GPX_SENSE_FALL:     event_hit = ~level & prev;
            `GPX_SENSE_BOTH:     event_hit = level ^ prev;
            default:             event_hit = 1'b0;
        endcase
    end

endmodule

// >>> design/gpx_port.v
// Purpose: Eight-pin port with direction, options, alternates and ext irq
// Assumes: APB slave on pclk; pins are asynchronous; four irq vectors
// Notes:   Pins given as in/out/oe triplets plus pull-up enable
//          Pin outputs and the irq request lag their cause by one cycle
//          Pin levels reach reads and detectors two cycles after the pin
//          Writes to read-only offsets are accepted and have no effect
//          Pin i belongs to vector i mod NVEC
`timescale 1ns/1ps
`include "gpx_defines.vh"

module gpx_port #(
    parameter       NVEC       = 4,
    parameter [7:0] OPTION_RST = `GPX_RST_OPTION
) (
    // Clock and reset
    input  wire        pclk,
    input  wire        presetn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [11:0] paddr,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Pins
    input  wire [7:0]  pin_in,
    output reg  [7:0]  pin_out,
    output reg  [7:0]  pin_oe,
    output reg  [7:0]  pin_pullup_en,
    // Alternate functions from and to peripherals
    input  wire [7:0]  alt_out_en,
    input  wire [7:0]  alt_out,
    output reg  [7:0]  alt_in,
    // External interrupts
    input  wire [NVEC-1:0] vec_fetch,
    output reg  [NVEC-1:0] ext_irq_req
);

    // ****************************************************************
    // Registers and state
    // ****************************************************************
    // Pending, sensitivity, hits and source levels are per vector; latch, direction and option are per pin
    reg  [7:0]        port_latch_register;
    reg  [7:0]        pin_direction_bit;
    reg  [7:0]        pin_option_bit;
    reg  [2*NVEC-1:0] ext_irq_sensitivity_register;
    reg  [NVEC-1:0]   pending;
    wire [7:0]        pin_sync;
    wire [NVEC-1:0]   vec_hit;
    reg  [7:0]        det_in;
    reg  [NVEC-1:0]   vec_level;
    reg  [7:0]        read_value;
    reg  [7:0]        next_pin_out;
    reg  [7:0]        next_pin_oe;
    reg  [7:0]        next_pullup;
    reg  [7:0]        next_alt_in;
    reg  [31:0]       next_prdata;
    reg               addr_ok;
    wire              wr_access;
    wire              rd_access;
    wire              sense_wr;
    integer           i;
    integer           j;
    integer           k;

    // Pin i belongs to vector (i mod NVEC)
    function [NVEC-1:0] vec_of;
        input integer pin;
        begin
            vec_of = {{(NVEC-1){1'b0}}, 1'b1} << (pin % NVEC);
        end
    endfunction

    // Writes land at the access edge; reads capture in setup
    assign wr_access = psel & penable & pwrite;
    assign rd_access = psel & ~penable & ~pwrite;
    assign sense_wr  = wr_access & (paddr == `GPX_OFF_SENSE);

    // ****************************************************************
    // Pin synchroniser
    // ****************************************************************
    // Nothing reads a pin before the second flop; avoids metastable fan-out
    gpx_sync #(
        .WIDTH    (8)
    ) u_sync (
        .clk      (pclk),
        .rst_n    (presetn),
        .async_in (pin_in),
        .sync_out (pin_sync)
    );

    // ****************************************************************
    // Interrupt source combination
    // ****************************************************************
    // Vector source is the AND of its enabled pins: one low pin holds
    // the source low and hides edges on the other pins of its group.
    // Disabled or output pins feed a one so they never mask others
    always @* begin
        for (i = 0; i < 8; i = i + 1) begin
            det_in[i] = (~pin_direction_bit[i] & pin_option_bit[i]) ? pin_sync[i]
                                                                     : 1'b1;
        end
        // Clear each vector's bit for every low enabled pin
        vec_level = {NVEC{1'b1}};
        for (i = 0; i < 8; i = i + 1) begin
            if (!det_in[i]) begin
                vec_level = vec_level & ~vec_of(i);
            end
        end
    end

    // Sensitivity codes per vector, two bits each:
    //   0 falling edge and low level, 1 rising edge,
    //   2 falling edge, 3 either edge
    // Detector history resets high so release of reset makes no edge
    genvar g;
    generate
        for (g = 0; g < NVEC; g = g + 1) begin : g_vec
            gpx_edge_det u_det (
                .clk       (pclk),
                .rst_n     (presetn),
                .level     (vec_level[g]),
                .sense     (ext_irq_sensitivity_register[2*g+1:2*g]),
                .event_hit (vec_hit[g])
            );
        end
    endgenerate

    // ****************************************************************
    // Pending latches
    // ****************************************************************
    // Hit wins over fetch; a sensitivity change clears outright
    // Level mode sets again every cycle while the source stays low
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pending <= {NVEC{1'b0}};
        end else begin
            for (j = 0; j < NVEC; j = j + 1) begin
                if (sense_wr && pwdata[2*j+:2] != ext_irq_sensitivity_register[2*j+:2]) begin
                    pending[j] <= 1'b0;
                end else if (vec_hit[j]) begin
                    pending[j] <= 1'b1;
                end else if (vec_fetch[j]) begin
                    pending[j] <= 1'b0;
                end
            end
        end
    end

    // ****************************************************************
    // Register writes
    // ****************************************************************
    // Writes land at the access edge; read-only offsets are ignored
    // Option reset is a parameter: one port has a bit that resets high
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            port_latch_register          <= `GPX_RST_LATCH;
            pin_direction_bit            <= `GPX_RST_DIR;
            pin_option_bit               <= OPTION_RST;
            ext_irq_sensitivity_register <= {(2*NVEC){1'b0}};
        end else if (wr_access) begin
            case (paddr)
                `GPX_OFF_LATCH:  port_latch_register <= pwdata[7:0];
                `GPX_OFF_DIR:    pin_direction_bit   <= pwdata[7:0];
                `GPX_OFF_OPTION: pin_option_bit      <= pwdata[7:0];
                `GPX_OFF_SENSE:  ext_irq_sensitivity_register <= pwdata[2*NVEC-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************************************
    // Pin drive and alternate routing
    // ****************************************************************
    // Mode per pin, alternate output first:
    //   alternate enabled : peripheral drives, no pull-up
    //   dir 1, option 1   : push-pull from the latch
    //   dir 1, option 0   : open-drain, released on a one
    //   dir 0, option 1   : pull-up input, interrupt capable
    //   dir 0, option 0   : floating input, feeds the alternate input
    // Data read: latch in output mode, else alternate output, else pin
    // Registered so outputs come from flops; one cycle of drive latency
    always @* begin
        for (k = 0; k < 8; k = k + 1) begin
            if (alt_out_en[k]) begin
                next_pin_out[k] = alt_out[k];
                next_pin_oe[k]  = 1'b1;
                next_pullup[k]  = 1'b0;
            end else if (pin_direction_bit[k]) begin
                // Open-drain releases on one; push-pull drives it high
                next_pin_out[k] = port_latch_register[k];
                next_pin_oe[k]  = ~port_latch_register[k] | pin_option_bit[k];
                next_pullup[k]  = 1'b0;
            end else begin
                next_pin_out[k] = 1'b0;
                next_pin_oe[k]  = 1'b0;
                next_pullup[k]  = pin_option_bit[k];
            end
            // Alternate input sees the latch in output mode, the pin otherwise
            next_alt_in[k] = pin_direction_bit[k] ? port_latch_register[k]
                                                  : pin_sync[k];
            if (pin_direction_bit[k]) begin
                read_value[k] = port_latch_register[k];
            end else if (alt_out_en[k]) begin
                read_value[k] = alt_out[k];
            end else begin
                read_value[k] = pin_sync[k];
            end
        end
    end

    // Output flops; the request drops in the cycle after a fetch
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out       <= 8'h00;
            pin_oe        <= 8'h00;
            pin_pullup_en <= 8'h00;
            alt_in        <= 8'h00;
            ext_irq_req   <= {NVEC{1'b0}};
        end else begin
            pin_out       <= next_pin_out;
            pin_oe        <= next_pin_oe;
            pin_pullup_en <= next_pullup;
            alt_in        <= next_alt_in;
            ext_irq_req   <= next_pending_req(pending, vec_fetch);
        end
    end

    // Request drops the cycle after a fetch is seen,
    // so the core never sees a request it has just serviced
    function [NVEC-1:0] next_pending_req;
        input [NVEC-1:0] p;
        input [NVEC-1:0] f;
        begin
            next_pending_req = p & ~f;
        end
    endfunction

    // ****************************************************************
    // APB read path and answer
    // ****************************************************************
    // Read data is captured in setup; access completes with no wait
    // Offset map: 00 latch/pin, 04 direction, 08 option, 0c sensitivity,
    // 10 pending, 14 alternate enables, 18 alternate input value,
    // 1c synchronised pin level; all other offsets are refused
    always @* begin
        addr_ok     = 1'b1;
        next_prdata = 32'h0000_0000;
        case (paddr)
            `GPX_OFF_LATCH:      next_prdata[7:0] = read_value;
            `GPX_OFF_DIR:        next_prdata[7:0] = pin_direction_bit;
            `GPX_OFF_OPTION:     next_prdata[7:0] = pin_option_bit;
            `GPX_OFF_SENSE:      next_prdata[2*NVEC-1:0] = ext_irq_sensitivity_register;
            `GPX_OFF_PENDING:    next_prdata[NVEC-1:0] = pending;
            `GPX_OFF_ALT_OUT_EN: next_prdata[7:0] = alt_out_en;
            `GPX_OFF_ALT_IN_EN:  next_prdata[7:0] = next_alt_in;
            `GPX_OFF_PIN_LEVEL:  next_prdata[7:0] = pin_sync;
            default:             addr_ok = 1'b0;
        endcase
    end

    // Fixed one-cycle answer; no wait states, error on unmapped offsets
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel & ~penable;
            pslverr <= psel & ~penable & ~addr_ok;
            if (rd_access) begin
                prdata <= next_prdata;
            end
        end
    end

endmodule

// >>> verif/gpx_chk_asserts.sv
// Purpose: Port-level checks of the eight-pin port
// Assumes: One clock domain, presetn asynchronous and active low
// Notes:   Bound into gpx_port below the module
`timescale 1ns/1ps

module gpx_chk #(
    parameter NVEC = 4
) (
    // Clock and reset
    input wire            pclk,
    input wire            presetn,
    // APB
    input wire            psel,
    input wire            penable,
    input wire            pwrite,
    input wire [11:0]     paddr,
    input wire            pready,
    input wire            pslverr,
    // Pins and alternates
    input wire [7:0]      pin_out,
    input wire [7:0]      pin_oe,
    input wire [7:0]      pin_pullup_en,
    input wire [7:0]      alt_out_en,
    input wire [7:0]      alt_out,
    // Interrupts
    input wire [NVEC-1:0] vec_fetch,
    input wire [NVEC-1:0] ext_irq_req
);
    // ****************
    // Properties
    // ****************
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // Only a write to offset 0c changes sensitivity and clears, but any write is taken as cause
    wire wr_acc = psel & penable & pwrite;

    a_ready_access: assert property (psel && !penable |=> pready)
        else $error("no answer in access cycle");
    a_ready_only: assert property (pready |-> psel && penable && !$past(penable))
        else $error("answer outside access cycle");
    a_err_unmapped: assert property (psel && !penable && paddr >= 12'h020 |=> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (pready && paddr < 12'h020 |-> !pslverr)
        else $error("mapped access refused");
    a_reset_quiet: assert property ($rose(presetn) |-> pin_oe == 8'h00
        && pin_pullup_en == 8'h00 && ext_irq_req == 0)
        else $error("outputs active after reset");
    a_pullup_drive: assert property ((pin_pullup_en & pin_oe) == 8'h00)
        else $error("pull-up on a driven pin");
    a_alt_override: assert property (($stable(alt_out_en) && $stable(alt_out)) [*2] |->
        (pin_oe & alt_out_en) == alt_out_en && (pin_out & alt_out_en) == (alt_out & alt_out_en))
        else $error("alternate output not on pin");
    a_req_hold: assert property ((($past(ext_irq_req) & ~ext_irq_req & ~$past(vec_fetch)
        & ~$past(vec_fetch, 2)) != 0) |-> $past(wr_acc) || $past(wr_acc, 2))
        else $error("request dropped without cause");

    c_refused: cover property (pready && pslverr);
    c_request: cover property ($rose(ext_irq_req[0]));
    c_alt_drive: cover property ((alt_out_en & pin_oe) != 8'h00);
endmodule

bind gpx_port gpx_chk #(.NVEC(NVEC)) gpx_chk_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pready(pready), .pslverr(pslverr), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_pullup_en(pin_pullup_en), .alt_out_en(alt_out_en), .alt_out(alt_out),
    .vec_fetch(vec_fetch), .ext_irq_req(ext_irq_req)
);

// >>> verif/gpx_pins.sv
// Purpose: Board-side model of the eight pins
// Assumes: Device drive wins over the outside driver
// Notes:   An undriven line without pull-up never holds a steady level
`timescale 1ns/1ps

module gpx_pins (
    // Clock
    input  wire       pclk,
    // Device side
    input  wire [7:0] pin_out,
    input  wire [7:0] pin_oe,
    input  wire [7:0] pin_pullup_en,
    // Outside driver
    input  wire [7:0] ext_en,
    input  wire [7:0] ext_val,
    output wire [7:0] pin_in
);
    reg [7:0] wander = 8'h5a;

    // Floating level flips every cycle so a stale read cannot pass
    always @(posedge pclk) begin
        wander <= ~wander;
    end

    // Resolved wire level per pin
    assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_en & ext_val)
                  | (~pin_oe & ~ext_en & (pin_pullup_en | wander));
endmodule

// >>> verif/tb.sv
// Purpose: Self-checking bench for the eight-pin port
// Assumes: Reads scored by a monitor from a queue of expectations
// Notes:   Vector i holds pins i and i+4
`timescale 1ns/1ps
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("BAD %s exp %h got %h", n, e, g); end end

module tb;
    // ****************
    // Signals
    // ****************
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr;
    logic [7:0]  pin_in, pin_out, pin_oe, pin_pullup_en, alt_in;
    logic [7:0]  alt_out_en = 8'h00;
    logic [7:0]  alt_out = 8'h00;
    logic [7:0]  ext_en = 8'hff;
    logic [7:0]  ext_val = 8'hff;
    logic [3:0]  vec_fetch = 4'h0;
    logic [3:0]  ext_irq_req;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    logic [31:0] seed;
    logic [7:0]  v;
    int          err_count = 0;
    int          checks_done = 0;

    gpx_port #(.NVEC(4)) gpx_port_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .alt_out_en(alt_out_en), .alt_out(alt_out), .alt_in(alt_in),
        .vec_fetch(vec_fetch), .ext_irq_req(ext_irq_req)
    );
    gpx_pins gpx_pins_i (
        .pclk(pclk), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pullup_en),
        .ext_en(ext_en), .ext_val(ext_val), .pin_in(pin_in)
    );

    always #2.5 pclk = ~pclk;

    // ****************
    // Tasks
    // ****************
    // One APB transfer; a read notes its expected {pslverr, prdata}
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [32:0] e);
        int n;
        n = 0;
        if (!w)
            exp_q.push_back(e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20)
            err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 33'h0);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0, {25'h0, e});
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic fetch(input logic [3:0] m);
        vec_fetch <= m;
        @(posedge pclk);
        vec_fetch <= 4'h0;
        @(posedge pclk);
    endtask
    task end_of_test;
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    // Read monitor takes the oldest note per answered read
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size() > 0) begin
            exp_v = exp_q.pop_front();
            `CHK("read", exp_v, {pslverr, prdata})
        end
    end

    // Watchdog well beyond the expected three hundred or so cycles
    initial begin
        #100000;
        err_count++;
        end_of_test;
    end

    // ****************
    // Scenarios
    // ****************
    initial begin
        seed = 32'he91558c9;
        v = 8'($random(seed));
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        ext_val <= v;
        @(posedge pclk);
        for (int i = 1; i < 6; i++)
            rd(12'(4 * i), 8'h00);
        rd(12'h000, v);
        rd(12'h01c, v);
        rd(12'h018, v);
        wr(12'h000, 32'ha5);
        rd(12'h000, v);
        `CHK("pin_oe", 8'h00, pin_oe)
        apb(1'b0, 12'h020, 32'h0, {1'b1, 32'h0});
        ext_en <= 8'h00;
        wr(12'h004, 32'hff);
        wr(12'h008, 32'hff);
        rd(12'h000, 8'ha5);
        rd(12'h01c, 8'ha5);
        `CHK("pin_out", 8'ha5, pin_out)
        `CHK("pin_oe", 8'hff, pin_oe)
        wr(12'h008, 32'h00);
        tk(2);
        `CHK("od oe", 8'h5a, pin_oe)
        `CHK("od low", 8'h00, pin_out & pin_oe)
        `CHK("pullup", 8'h00, pin_pullup_en)
        wr(12'h000, 32'h3c);
        tk(2);
        `CHK("alt_in", 8'h3c, alt_in)
        ext_en <= 8'hff;
        wr(12'h004, 32'h00);
        wr(12'h008, 32'hff);
        tk(2);
        `CHK("pullup", 8'hff, pin_pullup_en)
        `CHK("pin_oe", 8'h00, pin_oe)
        ext_val <= 8'hff;
        alt_out_en <= 8'h0f;
        alt_out <= 8'h05;
        wr(12'h008, 32'h00);
        `CHK("alt oe", 8'h0f, pin_oe)
        `CHK("alt out", 8'h05, pin_out & 8'h0f)
        rd(12'h000, 8'hf5);
        alt_out_en <= 8'h00;
        wr(12'h00c, 32'h55);
        wr(12'h008, 32'h01);
        wr(12'h00c, 32'h56);
        fetch(4'hf);
        rd(12'h010, 8'h00);
        ext_val <= 8'hfe;
        tk(5);
        `CHK("irq", 4'h1, ext_irq_req)
        rd(12'h010, 8'h01);
        fetch(4'h1);
        rd(12'h010, 8'h00);
        wr(12'h008, 32'h00);
        wr(12'h008, 32'h01);
        tk(3);
        rd(12'h010, 8'h01);
        wr(12'h00c, 32'h55);
        rd(12'h010, 8'h00);
        ext_val <= 8'hff;
        tk(5);
        wr(12'h00c, 32'h55);
        rd(12'h010, 8'h01);
        ext_val <= 8'hef;
        wr(12'h008, 32'h11);
        wr(12'h00c, 32'h56);
        fetch(4'hf);
        ext_val <= 8'hee;
        tk(5);
        rd(12'h010, 8'h00);
        wr(12'h008, 32'h02);
        for (int c = 0; c < 4; c++) begin
            ext_val <= 8'hff;
            wr(12'h00c, {24'h0, 4'h5, 2'(c), 2'h1});
            tk(5);
            fetch(4'hf);
            ext_val <= 8'hfd;
            tk(5);
            rd(12'h010, {6'h0, c != 1, 1'b0});
            fetch(4'hf);
            ext_val <= 8'hff;
            tk(5);
            rd(12'h010, {6'h0, c != 2, 1'b0});
        end
        // Safe disable of pin 1 while it is held low
        ext_val <= 8'hfd;
        tk(5);
        wr(12'h00c, 32'h59);
        wr(12'h008, 32'h00);
        wr(12'h00c, 32'h55);
        tk(3);
        rd(12'h010, 8'h00);
        // Reset in mid-run returns every register to its reset value
        presetn <= 1'b0;
        tk(2);
        presetn <= 1'b1;
        tk(1);
        rd(12'h004, 8'h00);
        rd(12'h00c, 8'h00);
        rd(12'h000, 8'hfd);
        `CHK("pullup", 8'h00, pin_pullup_en)
        end_of_test;
    end
endmodule
